/* File: rtl/ssrm_pkg.sv */
/*
 * Shared constants and types of the reduced-speed monitor: register map,
 * field positions, reset values, frequency bounds, modes and carriers.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
`default_nettype none

package ssrm_pkg;

    // bus shape
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SPD_W = 16;
    localparam int unsigned STAGE_W = 2;
    localparam int unsigned STAGES = 4;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_FREQ_LIM = 8'h10;
    localparam logic [7:0] OFS_SW_DELAY = 8'h14;
    localparam logic [7:0] OFS_LIMIT = 8'h20;
    localparam logic [7:0] LIMIT_DEC_MASK = 8'hF0;
    localparam int unsigned LIMIT_IDX_LSB = 2;

    // interrupt bit positions
    localparam int unsigned IRQ_SPEED = 0;
    localparam int unsigned IRQ_ENC_FREQ = 1;
    localparam int unsigned IRQ_XCHECK = 2;
    localparam int unsigned IRQ_DEFECT = 3;
    localparam int unsigned IRQ_AMPL = 4;
    localparam int unsigned IRQ_W = 5;

    // frequency bounds in kHz
    localparam logic [15:0] FREQ_MIN_KHZ = 16'h012C;
    localparam logic [15:0] FREQ_MAX_KHZ = 16'h01A4;
    localparam logic [15:0] AMPL_MAX_KHZ = 16'h01A4;

    // reset values
    localparam logic [15:0] FREQ_LIM_RST = 16'h012C;
    localparam logic [15:0] SW_DELAY_RST = 16'h0010;
    localparam logic [15:0] LIMIT_RST = 16'h0100;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_STANDSTILL,
        MODE_REDUCED
    } ssrm_mode_e;

    // control register, bit 3 downward
    typedef struct packed {
        logic stop_clr;
        logic fixed_variant;
        logic single_enc;
        logic enable;
    } ssrm_ctrl_s;

    localparam ssrm_ctrl_s CTRL_RST = '0;

    // status register low half
    typedef struct packed {
        logic pending;
        logic [1:0] stage;
        logic ampl_active;
        logic stop;
        logic standstill;
        logic active;
    } ssrm_status_s;

endpackage

`default_nettype wire

/* File: rtl/ssrm_limit_mem.sv */
/*
 * Four-entry speed limit table with one byte-lane write port and two
 * registered read ports (bus side and monitor side).
 * Assumes the write enable is a single-cycle strobe.
 */
`timescale 1ns/1ns
`default_nettype none

module ssrm_limit_mem
    import ssrm_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic we,
    input wire logic [1:0] wr_be,
    input wire logic [STAGE_W-1:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic [STAGE_W-1:0] rd_a_idx,
    output logic [15:0] rd_a_data,
    input wire logic [STAGE_W-1:0] rd_b_idx,
    output logic [15:0] rd_b_data
);

    logic [15:0] mem_q [STAGES];
    logic [15:0] mem_d [STAGES];

    // byte-lane merge into the addressed word
    always_comb begin
        for (int i = 0; i < STAGES; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (we) begin
            if (wr_be[0]) begin
                mem_d[wr_idx][7:0] = wr_data[7:0];
            end
            if (wr_be[1]) begin
                mem_d[wr_idx][15:8] = wr_data[15:8];
            end
        end
    end

    // storage and registered reads
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                mem_q[i] <= LIMIT_RST;
            end
            rd_a_data <= LIMIT_RST;
            rd_b_data <= LIMIT_RST;
        end else begin
            for (int i = 0; i < STAGES; i++) begin
                mem_q[i] <= mem_d[i];
            end
            rd_a_data <= mem_q[rd_a_idx];
            rd_b_data <= mem_q[rd_b_idx];
        end
    end

endmodule // ssrm_limit_mem

`default_nettype wire

/* File: rtl/ssrm_monitor.sv */
/*
 * Per-axis reduced-speed and standstill selection monitor with encoder
 * limit-frequency check, channel cross-check and Wishbone registers.
 * Assumes monitor_tick is a one-cycle strobe per monitoring cycle and
 * all inputs are synchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none

module ssrm_monitor
    import ssrm_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic monitor_tick,
    input wire logic [SPD_W-1:0] speed_actual,
    input wire logic [15:0] enc_freq_khz,
    input wire logic enc_amplitude_ok,
    input wire logic [15:0] peer_freq_limit,
    input wire logic monitor_off_input,
    input wire logic standstill_off_input,
    input wire logic [STAGE_W-1:0] stage_sel,
    output logic monitor_active_flag,
    output logic standstill_active_flag,
    output logic [STAGE_W-1:0] active_stage,
    output logic amplitude_check_active,
    output logic stop_request,
    output logic irq
);

    function automatic logic over_limit(input logic [15:0] val,
                                        input logic [15:0] lim);
        over_limit = val > lim;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = dat[15:8];
        end
    endfunction

    // bus state
    logic ack_q, ack_d;
    logic [DATA_W-1:0] dat_q, dat_d;
    logic lim_rd_q, lim_rd_d;
    ssrm_ctrl_s ctrl_q, ctrl_d;
    logic [IRQ_W-1:0] mask_q, mask_d;
    logic [15:0] freq_lim_q, freq_lim_d;
    logic [15:0] sw_delay_q, sw_delay_d;
    logic [IRQ_W-1:0] w1c;
    logic stop_clr;
    logic wr, lim_hit, lim_we;
    logic [15:0] freq_new;
    // limit stage state
    logic [STAGE_W-1:0] sel_q, sel_d, stage_q, stage_d;
    logic [STAGE_W-1:0] pend_stage_q, pend_stage_d;
    logic pend_q, pend_d;
    logic [15:0] lim_q, lim_d, cnt_q, cnt_d;
    logic [15:0] rd_a_data, rd_b_data;
    // monitor state
    ssrm_mode_e mode;
    logic [15:0] freq_eff;
    logic [IRQ_W-1:0] ev, stat_q, stat_d;
    logic active_q, active_d, standstill_q, standstill_d;
    logic stop_q, stop_d, ampl_q, ampl_d;
    ssrm_status_s status;

    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign lim_hit = (wb_adr_i & LIMIT_DEC_MASK) == OFS_LIMIT;
    assign lim_we = wr & lim_hit;

    ssrm_limit_mem u_limit_mem (
        .clk(clk),
        .arst_n(arst_n),
        .we(lim_we),
        .wr_be(wb_sel_i[1:0]),
        .wr_idx(wb_adr_i[LIMIT_IDX_LSB +: STAGE_W]),
        .wr_data(wb_dat_i[15:0]),
        .rd_a_idx(wb_adr_i[LIMIT_IDX_LSB +: STAGE_W]),
        .rd_a_data(rd_a_data),
        .rd_b_idx(stage_sel),
        .rd_b_data(rd_b_data)
    );

    assign status = '{pending: pend_q, stage: stage_q, ampl_active: ampl_q,
                      stop: stop_q, standstill: standstill_q,
                      active: active_q};

    // bus decode; writes land on the edge where the master sees ack
    always_comb begin
        ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
        dat_d = dat_q;
        lim_rd_d = lim_rd_q;
        ctrl_d = ctrl_q;
        ctrl_d.stop_clr = 1'b0;
        mask_d = mask_q;
        freq_lim_d = freq_lim_q;
        sw_delay_d = sw_delay_q;
        w1c = '0;
        freq_new = merge16(freq_lim_q, wb_dat_i, wb_sel_i);
        if (ack_d) begin
            lim_rd_d = lim_hit;
            case (wb_adr_i)
                OFS_CTRL: dat_d = {28'h0000000, ctrl_q};
                OFS_STATUS: dat_d = {lim_q, 9'h000, status};
                OFS_IRQ_STAT: dat_d = {27'h0000000, stat_q};
                OFS_IRQ_MASK: dat_d = {27'h0000000, mask_q};
                OFS_FREQ_LIM: dat_d = {16'h0000, freq_lim_q};
                OFS_SW_DELAY: dat_d = {16'h0000, sw_delay_q};
                default: dat_d = '0; // unmapped reads zero
            endcase
        end
        if (wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                OFS_CTRL: ctrl_d = ssrm_ctrl_s'(wb_dat_i[3:0]);
                OFS_IRQ_STAT: w1c = wb_dat_i[IRQ_W-1:0];
                OFS_IRQ_MASK: mask_d = wb_dat_i[IRQ_W-1:0];
                default: ;
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                OFS_FREQ_LIM: begin
                    // clamp into the legal window
                    if (freq_new < FREQ_MIN_KHZ) begin
                        freq_lim_d = FREQ_MIN_KHZ;
                    end else if (freq_new > FREQ_MAX_KHZ) begin
                        freq_lim_d = FREQ_MAX_KHZ;
                    end else begin
                        freq_lim_d = freq_new;
                    end
                end
                OFS_SW_DELAY: sw_delay_d = merge16(sw_delay_q, wb_dat_i,
                                                   wb_sel_i);
                default: ;
            endcase
        end
    end

    assign stop_clr = ctrl_q.stop_clr;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            dat_q <= '0;
            lim_rd_q <= 1'b0;
            ctrl_q <= CTRL_RST;
            mask_q <= IRQ_MASK_RST;
            freq_lim_q <= FREQ_LIM_RST;
            sw_delay_q <= SW_DELAY_RST;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            lim_rd_q <= lim_rd_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            freq_lim_q <= freq_lim_d;
            sw_delay_q <= sw_delay_d;
        end
    end

    // limit table word comes straight from its own read register
    assign wb_dat_o = lim_rd_q ? {16'h0000, rd_a_data} : dat_q;
    assign wb_ack_o = ack_q;

    // stage changeover; sel_q lines up with the registered table read
    always_comb begin
        sel_d = stage_sel;
        stage_d = stage_q;
        lim_d = lim_q;
        pend_d = pend_q;
        pend_stage_d = pend_stage_q;
        cnt_d = cnt_q;
        if (sel_q == stage_q) begin
            lim_d = rd_b_data; // follows table edits
            pend_d = 1'b0;
        end else if (!over_limit(lim_q, rd_b_data)) begin
            stage_d = sel_q; // raising takes effect at once
            lim_d = rd_b_data;
            pend_d = 1'b0;
        end else if (!pend_q || pend_stage_q != sel_q) begin
            pend_d = 1'b1; // lowering starts the delay
            pend_stage_d = sel_q;
            cnt_d = sw_delay_q;
        end else if (cnt_q == CNT_ZERO) begin
            stage_d = sel_q; // delay over, lower limit enforced
            lim_d = rd_b_data;
            pend_d = 1'b0;
        end else if (monitor_tick) begin
            cnt_d = cnt_q - CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_q <= '0;
            stage_q <= '0;
            lim_q <= LIMIT_RST;
            pend_q <= 1'b0;
            pend_stage_q <= '0;
            cnt_q <= CNT_ZERO;
        end else begin
            sel_q <= sel_d;
            stage_q <= stage_d;
            lim_q <= lim_d;
            pend_q <= pend_d;
            pend_stage_q <= pend_stage_d;
            cnt_q <= cnt_d;
        end
    end

    // mode decode; a cleared enable or monitor_off_input selects MODE_OFF, which drops the active and standstill flags and the speed and frequency checks
    always_comb begin
        if (!ctrl_q.enable || monitor_off_input) begin
            mode = MODE_OFF;
        end else if (!standstill_off_input) begin
            mode = MODE_STANDSTILL;
        end else begin
            mode = MODE_REDUCED;
        end
    end

    // fixed variant keeps the base limit whatever was written
    assign freq_eff = ctrl_q.fixed_variant ? FREQ_MIN_KHZ : freq_lim_q;

    // per-tick checks; each event lands in status one edge later
    always_comb begin
        ev = '0;
        if (monitor_tick) begin
            case (mode)
                MODE_REDUCED: begin
                    // also catches entry above limit
                    ev[IRQ_SPEED] = over_limit(speed_actual, lim_q);
                end
                MODE_STANDSTILL, MODE_OFF: ev[IRQ_SPEED] = 1'b0;
                default: ev[IRQ_SPEED] = 1'b0;
            endcase
            // strictly above the limit only
            ev[IRQ_ENC_FREQ] = (mode != MODE_OFF) & ctrl_q.single_enc &
                               over_limit(enc_freq_khz, freq_eff);
            ev[IRQ_XCHECK] = freq_lim_q != peer_freq_limit;
            ev[IRQ_DEFECT] = ctrl_q.fixed_variant &
                             (freq_lim_q != FREQ_MIN_KHZ);
            ev[IRQ_AMPL] = ampl_q & ~enc_amplitude_ok;
        end
    end

    // flags, stop latch and sticky status; set beats clear
    always_comb begin
        active_d = mode != MODE_OFF;
        standstill_d = mode == MODE_STANDSTILL;
        ampl_d = ~over_limit(enc_freq_khz, AMPL_MAX_KHZ);
        // stop latched the edge after detection, well inside budget
        stop_d = (stop_q & ~stop_clr) | ev[IRQ_SPEED] | ev[IRQ_ENC_FREQ] |
                 ev[IRQ_DEFECT];
        stat_d = (stat_q & ~w1c) | ev;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active_q <= 1'b0;
            standstill_q <= 1'b0;
            ampl_q <= 1'b0;
            stop_q <= 1'b0;
            stat_q <= '0;
        end else begin
            active_q <= active_d;
            standstill_q <= standstill_d;
            ampl_q <= ampl_d;
            stop_q <= stop_d;
            stat_q <= stat_d;
        end
    end

    assign monitor_active_flag = active_q;
    assign standstill_active_flag = standstill_q;
    assign active_stage = stage_q;
    assign amplitude_check_active = ampl_q;
    assign stop_request = stop_q;
    assign irq = |(stat_q & mask_q);

endmodule // ssrm_monitor

`default_nettype wire

/* File: test/ssrm_axis_model.sv */
/* Axis-side model: monitoring tick, speed, encoder frequency, peer limit.
   Assumes the bench sets speed and frequency targets after clock edges. */
`timescale 1ns/1ns
`default_nettype none
module ssrm_axis_model
    import ssrm_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] spd,
    input wire logic [15:0] frq,
    input wire logic amp,
    output logic monitor_tick,
    output logic [SPD_W-1:0] speed_actual,
    output logic [15:0] enc_freq_khz,
    output logic enc_amplitude_ok,
    output logic [15:0] peer_freq_limit
);
    logic [1:0] div_q;
    // short monitoring cycle keeps every wait in the bench small
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    assign monitor_tick = (div_q == 2'h3);
    assign speed_actual = spd; // bench slows the axis before selecting
    assign enc_freq_khz = frq;
    // bench decides when the encoder amplitude drops out
    assign enc_amplitude_ok = amp;
    // peer channel keeps the default limit
    assign peer_freq_limit = 16'h012C;
endmodule // ssrm_axis_model
`default_nettype wire

/* File: test/ssrm_monitor_properties.sv */
/* Concurrent checks on the monitor's ports, bound after the module.
   Assumes one clock domain and a master that releases after ack. */
`timescale 1ns/1ns
`default_nettype none
module ssrm_monitor_properties
    import ssrm_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic monitor_tick,
    input wire logic [15:0] enc_freq_khz,
    input wire logic monitor_off_input,
    input wire logic standstill_off_input,
    input wire logic monitor_active_flag,
    input wire logic standstill_active_flag,
    input wire logic amplitude_check_active,
    input wire logic stop_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack");
    property p_off_quiet;
        monitor_off_input |=> !monitor_active_flag && !standstill_active_flag;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("flag on");
    property p_still_sel;
        standstill_active_flag |->
            !$past(monitor_off_input) && !$past(standstill_off_input);
    endproperty
    a_still_sel: assert property (p_still_sel) else $error("bad ss");
    property p_amp_high;
        (enc_freq_khz <= 16'h01A4) [*3] |-> amplitude_check_active;
    endproperty
    a_amp_high: assert property (p_amp_high) else $error("amp off");
    property p_amp_low;
        enc_freq_khz > 16'h01A4 |=> !amplitude_check_active;
    endproperty
    a_amp_low: assert property (p_amp_low) else $error("amp on");
    // bus writes excluded: a defect event may follow a parameter write
    property p_off_no_stop;
        monitor_off_input && !stop_request && !wb_cyc_i && !$past(wb_cyc_i)
            |=> !stop_request;
    endproperty
    a_off_no_stop: assert property (p_off_no_stop) else $error("stop");
    property p_stop_hold;
        stop_request && !wb_cyc_i && !$past(wb_cyc_i, 2) |=> stop_request;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop lost");
    property p_stop_cause;
        $rose(stop_request) |->
            $past(monitor_tick) || $past(wb_cyc_i) || $past(wb_cyc_i, 2);
    endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("bad stop");
endmodule // ssrm_monitor_properties
bind ssrm_monitor ssrm_monitor_properties u_props (.clk(clk),
    .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .monitor_tick(monitor_tick),
    .enc_freq_khz(enc_freq_khz), .monitor_off_input(monitor_off_input),
    .standstill_off_input(standstill_off_input),
    .monitor_active_flag(monitor_active_flag),
    .standstill_active_flag(standstill_active_flag),
    .amplitude_check_active(amplitude_check_active),
    .stop_request(stop_request));
`default_nettype wire

/* File: test/ssrm_monitor_tb.sv */
/* Self-checking bench of the monitor: Wishbone tasks and scenarios.
   Assumes the axis model and the bound property checker. */
`timescale 1ns/1ns
`default_nettype none
module ssrm_monitor_tb
    import ssrm_pkg::*;
;
    logic clk, arst_n, cyc, stb, we, ack, tick, amp_ok, off, soff, amp_in;
    logic f_mon, f_ss, f_amp, stop, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dw, dr, q;
    logic [15:0] spd, frq, spd_a, frq_a, peer;
    logic [1:0] stg, a_stg;
    int n_mismatch, check_count, cycles;
    ssrm_axis_model u_axis (.clk(clk), .arst_n(arst_n), .spd(spd),
        .frq(frq), .amp(amp_in), .monitor_tick(tick),
        .speed_actual(spd_a),
        .enc_freq_khz(frq_a), .enc_amplitude_ok(amp_ok),
        .peer_freq_limit(peer));
    ssrm_monitor u_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .monitor_tick(tick),
        .speed_actual(spd_a), .enc_freq_khz(frq_a),
        .enc_amplitude_ok(amp_ok), .peer_freq_limit(peer),
        .monitor_off_input(off), .standstill_off_input(soff),
        .stage_sel(stg), .monitor_active_flag(f_mon),
        .standstill_active_flag(f_ss), .active_stage(a_stg),
        .amplitude_check_active(f_amp), .stop_request(stop), .irq(irq));
    always #10 clk = ~clk;
    // watchdog: a hang ends the run as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h got %h", n, e, g);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = dr;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
        wb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        {clk, arst_n, cyc, stb, we, adr, dw, sel} = {45'h0, 4'hF};
        {off, soff, stg, spd, frq, amp_in} = {4'h8, 16'h0, 16'h0064, 1'b1};
        wt(3);
        arst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(OFS_LIMIT + 8'(4 * i), 32'h100, "limit_rst");
            wb(1'b1, OFS_LIMIT + 8'(4 * i), 32'h40 * (i + 1));
            rd(OFS_LIMIT + 8'(4 * i), 32'h40 * (i + 1), "limit");
        end
        rd(8'h40, 32'h0, "unmapped");
        rd(OFS_FREQ_LIM, 32'h12C, "freq_rst");
        wb(1'b1, OFS_FREQ_LIM, 32'h1F4);
        rd(OFS_FREQ_LIM, 32'h1A4, "freq_max");
        wb(1'b1, OFS_FREQ_LIM, 32'h64);
        rd(OFS_FREQ_LIM, 32'h12C, "freq_min");
        wb(1'b1, OFS_SW_DELAY, 32'h2);
        wb(1'b1, OFS_IRQ_MASK, 32'h1F);
        wb(1'b1, OFS_CTRL, 32'h3); // enable, single encoder
        wb(1'b1, OFS_IRQ_STAT, 32'h1F);
        wt(8);
        chk("flags_off", 32'h0, {f_mon, f_ss});
        {off, soff} <= 2'b00;
        wt(3);
        chk("flags_ss", 32'h3, {f_mon, f_ss});
        soff <= 1'b1;
        wt(3);
        chk("flags_red", 32'h2, {f_mon, f_ss});
        spd <= 16'h30;
        // rising stages switch at once
        for (int i = 0; i < 4; i++) begin
            stg <= 2'(i);
            wt(4);
            chk("stage_up", 32'(i), a_stg);
        end
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("enforced", 32'h100, q[31:16]);
        stg <= 2'h0;
        wt(4);
        chk("stage_hold", 32'h3, a_stg);
        wt(24);
        chk("stage_down", 32'h0, a_stg);
        spd <= 16'h40;
        wt(8);
        chk("stop_equal", 32'h0, stop);
        spd <= 16'h41;
        wt(8);
        chk("stop_over", 32'h3, {stop, irq});
        rd(OFS_IRQ_STAT, 32'h1, "speed_evt");
        spd <= 16'h30;
        wb(1'b1, OFS_IRQ_STAT, 32'h1F);
        wb(1'b1, OFS_CTRL, 32'hB);
        wt(2);
        chk("cleared", 32'h0, {stop, irq});
        wb(1'b1, OFS_IRQ_MASK, 32'h0);
        frq <= 16'h12C;
        wt(8);
        rd(OFS_IRQ_STAT, 32'h0, "freq_equal");
        frq <= 16'h12D;
        wt(8);
        rd(OFS_IRQ_STAT, 32'h2, "freq_over");
        chk("irq_masked", 32'h0, irq);
        wb(1'b1, OFS_IRQ_MASK, 32'h2);
        wt(1);
        chk("irq_unmask", 32'h1, irq);
        frq <= 16'h64;
        wb(1'b1, OFS_IRQ_STAT, 32'h1F);
        wb(1'b1, OFS_CTRL, 32'hB);
        wb(1'b1, OFS_FREQ_LIM, 32'h190);
        wt(4);
        rd(OFS_IRQ_STAT, 32'h4, "xcheck");
        {off, spd, frq} <= {1'b1, 16'hFFFF, 16'h1F4};
        wb(1'b1, OFS_IRQ_STAT, 32'h1F);
        wb(1'b1, OFS_CTRL, 32'hB);
        wt(8);
        chk("off_quiet", 32'h0, {stop, f_mon, f_ss, f_amp});
        frq <= 16'h1A4;
        wt(4);
        chk("amp_on", 32'h1, f_amp);
        amp_in <= 1'b0;
        wt(8);
        rd(OFS_IRQ_STAT, 32'h14, "ampl_evt");
        chk("ampl_no_stop", 32'h0, stop);
        {off, spd, frq, amp_in} <= {1'b0, 16'h30, 16'h12D, 1'b1};
        wb(1'b1, OFS_IRQ_STAT, 32'h1F);
        wb(1'b1, OFS_CTRL, 32'h7);
        wb(1'b1, OFS_FREQ_LIM, 32'h1A4);
        wt(8);
        wb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("fixed", 32'hA, q & 32'hA);
        chk("defect_stop", 32'h1, stop);
        close_out();
    end
endmodule // ssrm_monitor_tb
`default_nettype wire
